/* src/ilc_pkg.sv */
/*
  Package for the T1 in-band loop code generator and detectors.
  Assumes a single APB clock domain and 8-bit registers in 32-bit words.
*/
package ilc_pkg;

  // ==========================================================
  // Register indices (printed offsets, byte address = 4 * index)
  // ==========================================================
  localparam logic [9:0] IDX_RX_LEN_CTRL = 10'h082;
  localparam logic [9:0] IDX_RX_LATCHED = 10'h092;
  localparam logic [9:0] IDX_RX_SP_DEF1 = 10'h09C;
  localparam logic [9:0] IDX_RX_SP_DEF2 = 10'h09D;
  localparam logic [9:0] IDX_RX_MASK = 10'h0A2;
  localparam logic [9:0] IDX_RX_UP_DEF1 = 10'h0AC;
  localparam logic [9:0] IDX_RX_UP_DEF2 = 10'h0AD;
  localparam logic [9:0] IDX_RX_DN_DEF1 = 10'h0AE;
  localparam logic [9:0] IDX_RX_DN_DEF2 = 10'h0AF;
  localparam logic [9:0] IDX_RX_LIVE = 10'h0B2;
  localparam logic [9:0] IDX_TX_CTRL3 = 10'h183;
  localparam logic [9:0] IDX_TX_CTRL4 = 10'h186;
  localparam logic [9:0] IDX_TX_DEF1 = 10'h1AC;
  localparam logic [9:0] IDX_TX_DEF2 = 10'h1AD;
  localparam logic [9:0] IDX_SP_LEN_CTRL = 10'h09E;
  localparam logic [9:0] IDX_PORT_CFG = 10'h0C0;
  localparam int PORT_STRIDE = 32'h200;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int TX_LOOP_EN_BIT = 0;
  localparam int TX_LEN_LOW_BIT = 0;
  localparam int TX_LEN_HIGH_BIT = 1;
  localparam int TX_LEN_EXT_LSB = 2;
  localparam int CFG_T1_BIT = 0;
  localparam int CFG_NO_FBIT = 1;
  localparam int STAT_UP_BIT = 0;
  localparam int STAT_DN_BIT = 1;
  localparam int STAT_SP_BIT = 2;
  localparam int LOSS_OFFSET = 3;

  // ==========================================================
  // Length codes: 3-bit field, 0..6 -> 1..7 bits, 7 -> 8 bits
  // Receive up/down codes sit in ctrl[2:0] and ctrl[5:3];
  // ctrl[6] set selects 16 bits for both.
  // ==========================================================
  localparam logic [2:0] LEN_CODE_8 = 3'h7;
  localparam int RX_UP_LEN_LSB = 0;
  localparam int RX_DN_LEN_LSB = 3;
  localparam int RX_LEN16_BIT = 6;
  localparam int SP_LEN16_BIT = 3;

  // ==========================================================
  // Reset values and timing
  // ==========================================================
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h01;
  localparam int CLK_HZ = 25_000_000;
  localparam int INTEG_MS = 48;
  localparam int INTEG_BITS = 1544 * INTEG_MS;
  localparam int T1_FRAME_BITS = 193;
  localparam int ERR_LIMIT_DIV = 100;
  localparam int LOSS_LIMIT_DIV = 4;

  typedef struct packed {
    logic [15:0] code;
    logic [4:0] len;
  } ilc_pattern_t;

endpackage : ilc_pkg

/* src/ilc_loop_code.sv */
/*
  Loop code generator and three detectors with an APB register slave.
  Assumes tx and rx bit strobes synchronous to pclk, one per line bit.
*/
// Chosen here: the APB register port.
`timescale 1ns/100ps

module ilc_loop_code #(
  parameter int PORT_NUM = 1,
  parameter int INTEG_BITS = ilc_pkg::INTEG_BITS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_bit_stb,
  input wire logic tx_line_data,
  input wire logic tx_fbit_slot,
  output logic tx_out_data,
  input wire logic rx_bit_stb,
  input wire logic rx_line_data,
  output logic loop_code_irq_pend
);

  // ==========================================================
  // Bus decode
  // ==========================================================
  localparam logic [31:0] BASE = 32'((PORT_NUM - 1) * ilc_pkg::PORT_STRIDE * 4);
  logic [31:0] rel_addr;
  logic [9:0] idx;
  logic in_range;
  logic addr_above;
  logic addr_near;
  logic addr_aligned;
  logic wr_en;
  assign rel_addr = paddr - BASE;
  assign idx = rel_addr[11:2];
  // Foreign-port or misaligned addresses answer with an error and read zero
  assign addr_above = paddr >= BASE;
  assign addr_near = rel_addr[31:12] == 20'h00000;
  assign addr_aligned = rel_addr[1:0] == 2'h0;
  assign in_range = addr_above && addr_near && addr_aligned;
  assign wr_en = psel && penable && pwrite && in_range;
  // Zero wait states: every register answers in the access cycle
  assign pready = 1'b1;

  logic [7:0] rx_len_q, sp_len_q, mask_q, tx3_q, tx4_q, cfg_q;
  logic [7:0] tdef1_q, tdef2_q;
  logic [7:0] up1_q, up2_q, dn1_q, dn2_q, sp1_q, sp2_q;
  logic [5:0] latched_q;
  logic [2:0] live;
  logic t1_mode;
  assign t1_mode = cfg_q[ilc_pkg::CFG_T1_BIT];

  // ==========================================================
  // Writable registers
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_len_q <= ilc_pkg::RST_BYTE;
      sp_len_q <= ilc_pkg::RST_BYTE;
      mask_q <= ilc_pkg::RST_BYTE;
      tx3_q <= ilc_pkg::RST_BYTE;
      tx4_q <= ilc_pkg::RST_BYTE;
      cfg_q <= ilc_pkg::RST_CFG;
      tdef1_q <= ilc_pkg::RST_BYTE;
      tdef2_q <= ilc_pkg::RST_BYTE;
      up1_q <= ilc_pkg::RST_BYTE;
      up2_q <= ilc_pkg::RST_BYTE;
      dn1_q <= ilc_pkg::RST_BYTE;
      dn2_q <= ilc_pkg::RST_BYTE;
      sp1_q <= ilc_pkg::RST_BYTE;
      sp2_q <= ilc_pkg::RST_BYTE;
    end else if (wr_en) begin
      unique case (idx)
        ilc_pkg::IDX_RX_LEN_CTRL: rx_len_q <= pwdata[7:0];
        ilc_pkg::IDX_SP_LEN_CTRL: sp_len_q <= pwdata[7:0];
        ilc_pkg::IDX_RX_MASK: mask_q <= pwdata[7:0];
        ilc_pkg::IDX_TX_CTRL3: tx3_q <= pwdata[7:0];
        ilc_pkg::IDX_TX_CTRL4: tx4_q <= pwdata[7:0];
        ilc_pkg::IDX_PORT_CFG: cfg_q <= pwdata[7:0];
        ilc_pkg::IDX_TX_DEF1: tdef1_q <= pwdata[7:0];
        ilc_pkg::IDX_TX_DEF2: tdef2_q <= pwdata[7:0];
        ilc_pkg::IDX_RX_UP_DEF1: up1_q <= pwdata[7:0];
        ilc_pkg::IDX_RX_UP_DEF2: up2_q <= pwdata[7:0];
        ilc_pkg::IDX_RX_DN_DEF1: dn1_q <= pwdata[7:0];
        ilc_pkg::IDX_RX_DN_DEF2: dn2_q <= pwdata[7:0];
        ilc_pkg::IDX_RX_SP_DEF1: sp1_q <= pwdata[7:0];
        ilc_pkg::IDX_RX_SP_DEF2: sp2_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Read path and error answer
  // ==========================================================
  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    unique case (idx)
      ilc_pkg::IDX_RX_LEN_CTRL: rd_byte = rx_len_q;
      ilc_pkg::IDX_SP_LEN_CTRL: rd_byte = sp_len_q;
      ilc_pkg::IDX_RX_MASK: rd_byte = mask_q;
      ilc_pkg::IDX_TX_CTRL3: rd_byte = tx3_q;
      ilc_pkg::IDX_TX_CTRL4: rd_byte = tx4_q;
      ilc_pkg::IDX_PORT_CFG: rd_byte = cfg_q;
      ilc_pkg::IDX_TX_DEF1: rd_byte = tdef1_q;
      ilc_pkg::IDX_TX_DEF2: rd_byte = tdef2_q;
      ilc_pkg::IDX_RX_UP_DEF1: rd_byte = up1_q;
      ilc_pkg::IDX_RX_UP_DEF2: rd_byte = up2_q;
      ilc_pkg::IDX_RX_DN_DEF1: rd_byte = dn1_q;
      ilc_pkg::IDX_RX_DN_DEF2: rd_byte = dn2_q;
      ilc_pkg::IDX_RX_SP_DEF1: rd_byte = sp1_q;
      ilc_pkg::IDX_RX_SP_DEF2: rd_byte = sp2_q;
      ilc_pkg::IDX_RX_LIVE: rd_byte = {5'h00, live};
      ilc_pkg::IDX_RX_LATCHED: rd_byte = {2'h0, latched_q};
      default: rd_hit = 1'b0;
    endcase
    if (!in_range) begin
      rd_hit = 1'b0;
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h000000, rd_byte};
    end
  end
  assign pslverr = psel && penable && !rd_hit;

  // ==========================================================
  // Transmit generator
  // ==========================================================
  // 3-bit length field: two documented select bits plus one extension bit
  logic [2:0] tx_len_code;
  logic [4:0] tx_len;
  logic [3:0] tx_pos_q;
  logic tx_active;
  logic tx_fslot_take;
  assign tx_len_code = {tx4_q[ilc_pkg::TX_LEN_EXT_LSB], tx4_q[ilc_pkg::TX_LEN_HIGH_BIT],
                        tx4_q[ilc_pkg::TX_LEN_LOW_BIT]};
  // Code 0 means 5 bits (documented); others are local choices
  always_comb begin
    unique case (tx_len_code)
      3'h0: tx_len = 5'd5;
      3'h1: tx_len = 5'd6;
      3'h2: tx_len = 5'd7;
      3'h3: tx_len = 5'd16;
      3'h4: tx_len = 5'd1;
      3'h5: tx_len = 5'd2;
      3'h6: tx_len = 5'd3;
      3'h7: tx_len = 5'd4;
    endcase
  end
  assign tx_active = t1_mode && tx3_q[ilc_pkg::TX_LOOP_EN_BIT];
  // Framing slot overwrites a pattern bit; the pattern keeps its phase
  assign tx_fslot_take = tx_fbit_slot && !cfg_q[ilc_pkg::CFG_NO_FBIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pos_q <= 4'h0;
    end else if (!tx_active) begin
      tx_pos_q <= 4'h0;
    end else if (tx_bit_stb) begin
      tx_pos_q <= (5'(tx_pos_q) + 5'd1 >= tx_len) ? 4'h0 : tx_pos_q + 4'h1;
    end
  end

  // MSB of first register goes out first; 16-bit wraps into second register
  logic [15:0] tx_word;
  logic tx_pat_bit;
  assign tx_word = {tdef1_q, tdef2_q};
  assign tx_pat_bit = tx_word[4'hF - tx_pos_q];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_out_data <= 1'b0;
    end else if (tx_bit_stb) begin
      if (tx_active && !tx_fslot_take) begin
        tx_out_data <= tx_pat_bit;
      end else begin
        tx_out_data <= tx_line_data;
      end
    end
  end

  // ==========================================================
  // Receive detectors
  // ==========================================================
  // Sixteen bits of history cover the longest code
  logic [15:0] rx_hist_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_hist_q <= 16'h0000;
    end else if (rx_bit_stb) begin
      rx_hist_q <= {rx_hist_q[14:0], rx_line_data};
    end
  end

  function automatic logic [4:0] len_of(input logic [2:0] code, input logic is16);
    if (is16) begin
      len_of = 5'd16;
    end else begin
      len_of = 5'(code) + 5'd1;
    end
  endfunction

  ilc_pkg::ilc_pattern_t pat [3];
  logic [2:0] restart;
  assign pat[0].code = {up1_q, up2_q};
  assign pat[0].len = len_of(rx_len_q[ilc_pkg::RX_UP_LEN_LSB +: 3], rx_len_q[ilc_pkg::RX_LEN16_BIT]);
  assign pat[1].code = {dn1_q, dn2_q};
  assign pat[1].len = len_of(rx_len_q[ilc_pkg::RX_DN_LEN_LSB +: 3], rx_len_q[ilc_pkg::RX_LEN16_BIT]);
  assign pat[2].code = {sp1_q, sp2_q};
  assign pat[2].len = len_of(sp_len_q[2:0], sp_len_q[ilc_pkg::SP_LEN16_BIT]);
  // Least significant byte is the second register in a 16-bit code
  assign restart[0] = wr_en && (idx == ilc_pkg::IDX_RX_UP_DEF2 || idx == ilc_pkg::IDX_RX_UP_DEF1);
  assign restart[1] = wr_en && (idx == ilc_pkg::IDX_RX_DN_DEF2 || idx == ilc_pkg::IDX_RX_DN_DEF1);
  assign restart[2] = wr_en && (idx == ilc_pkg::IDX_RX_SP_DEF2 || idx == ilc_pkg::IDX_RX_SP_DEF1);

  // ==========================================================
  // Detection limits
  // ==========================================================
  // A line error shows twice in a period match, hence the doubled limit
  localparam logic [23:0] SET_LIMIT = 24'(2 * INTEG_BITS / ilc_pkg::ERR_LIMIT_DIV);
  // Looser hold limit keeps a noisy window from dropping a live code
  localparam logic [23:0] LOSS_LIMIT = 24'(INTEG_BITS / ilc_pkg::LOSS_LIMIT_DIV);

  logic [2:0] live_prev_q;
  for (genvar d = 0; d < 3; d++) begin : g_det
    // Compare received bit against bit that arrived one pattern length earlier
    // Period match needs no phase hunt; the reference check pins the code itself
    logic exp_bit;
    logic ref_hit;
    logic [15:0] ref_w;
    logic [15:0] mask_w;
    logic [23:0] bits_q;
    logic [23:0] errs_q;
    logic seen_q;
    logic det_q;
    logic [4:0] lenm;
    assign lenm = pat[d].len;
    assign exp_bit = rx_hist_q[4'(lenm - 5'd1)];
    // Top lenm bits are the reference, so short codes read register 1 only
    assign ref_w = pat[d].code >> (5'd16 - lenm);
    assign mask_w = 16'((17'h00001 << lenm) - 17'h00001);
    assign ref_hit = ((rx_hist_q ^ ref_w) & mask_w) == 16'h0000;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        bits_q <= 24'h000000;
        errs_q <= 24'h000000;
        seen_q <= 1'b0;
        det_q <= 1'b0;
      end else if (!t1_mode || restart[d]) begin
        bits_q <= 24'h000000;
        errs_q <= 24'h000000;
        seen_q <= 1'b0;
        det_q <= 1'b0;
      end else if (rx_bit_stb) begin
        // Period match tolerates framing bits and errors alike
        if (bits_q == 24'(INTEG_BITS - 1)) begin
          det_q <= seen_q && (errs_q <= (det_q ? LOSS_LIMIT : SET_LIMIT));
          bits_q <= 24'h000000;
          errs_q <= 24'h000000;
          seen_q <= 1'b0;
        end else begin
          bits_q <= bits_q + 24'h000001;
          errs_q <= errs_q + 24'(rx_line_data != exp_bit);
          seen_q <= seen_q | ref_hit;
        end
      end
    end
    assign live[d] = det_q;
  end

  // ==========================================================
  // Latched status, write-one-to-clear, mask
  // ==========================================================
  // Edges of the live bits feed the latched set and loss bits
  logic [5:0] ev;
  assign ev = {live_prev_q & ~live, live & ~live_prev_q};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_prev_q <= 3'h0;
    end else begin
      live_prev_q <= live;
    end
  end

  // Set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_q <= 6'h00;
    end else if (wr_en && idx == ilc_pkg::IDX_RX_LATCHED) begin
      latched_q <= (latched_q & ~pwdata[5:0]) | ev;
    end else begin
      latched_q <= latched_q | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_code_irq_pend <= 1'b0;
    end else begin
      loop_code_irq_pend <= |(latched_q & mask_q[5:0]);
    end
  end

endmodule : ilc_loop_code

/* verification/ilc_loop_code_assertions.sv */
/* Checker for the loop code block.
   Sees only the top ports; bound from the bench top file. */
`timescale 1ns/100ps
module ilc_loop_code_assertions #(
  parameter int PORT_NUM = 1,
  parameter int INTEG_BITS = 200
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_bit_stb,
  input wire logic tx_line_data,
  input wire logic tx_fbit_slot,
  input wire logic tx_out_data,
  input wire logic rx_bit_stb,
  input wire logic rx_line_data,
  input wire logic loop_code_irq_pend
);
  // ==========================================
  // Register shadows
  // ==========================================
  logic en_q, t1_q, nofb_q, hit;
  logic [7:0] mask_q;
  logic [31:0] off;
  assign off = paddr - 32'((PORT_NUM - 1) * 32'h800);
  always_comb begin
    case (off[11:2])
      ilc_pkg::IDX_RX_LEN_CTRL, ilc_pkg::IDX_RX_LATCHED, ilc_pkg::IDX_RX_SP_DEF1,
      ilc_pkg::IDX_RX_SP_DEF2, ilc_pkg::IDX_RX_MASK, ilc_pkg::IDX_RX_UP_DEF1,
      ilc_pkg::IDX_RX_UP_DEF2, ilc_pkg::IDX_RX_DN_DEF1, ilc_pkg::IDX_RX_DN_DEF2,
      ilc_pkg::IDX_RX_LIVE, ilc_pkg::IDX_TX_CTRL3, ilc_pkg::IDX_TX_CTRL4,
      ilc_pkg::IDX_TX_DEF1, ilc_pkg::IDX_TX_DEF2, ilc_pkg::IDX_SP_LEN_CTRL,
      ilc_pkg::IDX_PORT_CFG: hit = (off[31:12] == 20'h00000) && (off[1:0] == 2'h0);
      default: hit = 1'b0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      t1_q <= 1'b1;
      nofb_q <= 1'b0;
      mask_q <= 8'h00;
    end else if (psel && penable && pwrite && hit) begin
      if (off[11:2] == ilc_pkg::IDX_TX_CTRL3) en_q <= pwdata[0];
      if (off[11:2] == ilc_pkg::IDX_RX_MASK) mask_q <= pwdata[7:0];
      if (off[11:2] == ilc_pkg::IDX_PORT_CFG) begin
        t1_q <= pwdata[0];
        nofb_q <= pwdata[1];
      end
    end
  end
  // ==========================================
  // Properties
  // ==========================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  a_err_unmapped: assert property (psel && penable && !hit |-> pslverr)
    else $error("no error on unmapped access");
  a_ok_mapped: assert property (psel && penable && hit |-> !pslverr)
    else $error("error on mapped access");
  a_read_unmapped_zero: assert property (psel && penable && !pwrite && !hit |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_read_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read upper bits set");
  a_tx_idle_pass: assert property (tx_bit_stb && !(en_q && t1_q) |=> tx_out_data == $past(tx_line_data))
    else $error("line data not passed when idle");
  a_fslot_pass: assert property (tx_bit_stb && tx_fbit_slot && !nofb_q |=> tx_out_data == $past(tx_line_data))
    else $error("framing slot not passed");
  a_tx_hold: assert property (!tx_bit_stb |=> $stable(tx_out_data))
    else $error("tx bit moved without strobe");
  a_irq_masked: assert property (mask_q == 8'h00 && $past(mask_q) == 8'h00 |-> !loop_code_irq_pend)
    else $error("irq with all masked");
endmodule : ilc_loop_code_assertions

/* verification/ilc_far_end.sv */
/* Far-end T1 sender: repeating code, F-bit overwrite, rare bit errors.
   Assumes one line bit every four pclk cycles. */
`timescale 1ns/100ps
module ilc_far_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic send_en,
  input wire logic err_en,
  input wire logic [15:0] pat,
  input wire logic [4:0] plen,
  output logic rx_bit_stb,
  output logic rx_line_data
);
  logic [1:0] div_q;
  logic [4:0] idx_q;
  logic [7:0] fcnt_q;
  logic [7:0] ecnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'h0;
      idx_q <= 5'h00;
      fcnt_q <= 8'h00;
      ecnt_q <= 8'h00;
      rx_bit_stb <= 1'b0;
      rx_line_data <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      rx_bit_stb <= (div_q == 2'h3);
      if (div_q == 2'h3) begin
        idx_q <= (idx_q + 5'h01 >= plen) ? 5'h00 : idx_q + 5'h01;
        fcnt_q <= (fcnt_q == 8'hC0) ? 8'h00 : fcnt_q + 8'h01;
        ecnt_q <= (ecnt_q == 8'hF9) ? 8'h00 : ecnt_q + 8'h01;
        // Idle line is never quiet: random bits
        if (!send_en || fcnt_q == 8'h00) rx_line_data <= 1'($urandom);
        else rx_line_data <= pat[plen - idx_q - 5'h01] ^ (err_en && ecnt_q == 8'h00);
      end
    end
  end
endmodule : ilc_far_end

/* verification/tb_t1_inband_loop_code_gen_detect.sv */
/* Bench: APB host, tx framer strobes, far-end receive model.
   Assumes the checker and far-end model files compiled first. */
`timescale 1ns/100ps
module tb_t1_inband_loop_code_gen_detect;
  logic pclk, presetn, psel, penable, pwrite, tx_bit_stb, tx_line_data, tx_fbit_slot;
  logic pready, pslverr, tx_out_data, rx_bit_stb, rx_line_data, loop_code_irq_pend, er;
  logic send_en, err_en;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [15:0] pat;
  logic [4:0] plen;
  logic [7:0] d1, d2;
  logic q[$];
  logic lq[$];
  int errors, checked, k, p;
  int lens[8] = '{5, 6, 7, 16, 1, 2, 3, 4};
  logic [15:0] pats[3] = '{16'h0080, 16'h0038, 16'hA5C3};
  logic [4:0] plens[3] = '{5'h08, 5'h06, 5'h10};
  ilc_loop_code #(.INTEG_BITS(200)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_bit_stb(tx_bit_stb), .tx_line_data(tx_line_data),
    .tx_fbit_slot(tx_fbit_slot), .tx_out_data(tx_out_data), .rx_bit_stb(rx_bit_stb),
    .rx_line_data(rx_line_data), .loop_code_irq_pend(loop_code_irq_pend));
  ilc_far_end far (.pclk(pclk), .presetn(presetn), .send_en(send_en), .err_en(err_en),
    .pat(pat), .plen(plen), .rx_bit_stb(rx_bit_stb), .rx_line_data(rx_line_data));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task finish_test;
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {20'h00000, i, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a following call never re-drives psel in this time step
    @(posedge pclk);
  endtask : apb
  task tx_run(input int n, input logic f);
    q.delete();
    lq.delete();
    repeat (n) begin
      tx_bit_stb <= 1'b1;
      tx_fbit_slot <= f;
      tx_line_data <= 1'($urandom);
      @(posedge pclk);
      tx_bit_stb <= 1'b0;
      repeat (2) @(posedge pclk);
      lq.push_back(tx_line_data);
      q.push_back(tx_out_data);
    end
  endtask : tx_run
  // Any phase of the code is accepted; two full periods must match
  function logic ok_pat(input logic [15:0] c, input int n);
    int s, r, i;
    logic m;
    s = q.size() - 2 * n;
    ok_pat = 1'b0;
    for (r = 0; r < n; r++) begin
      m = 1'b1;
      for (i = 0; i < 2 * n; i++) if (q[s + i] !== c[n - 1 - (i + r) % n]) m = 1'b0;
      if (m) ok_pat = 1'b1;
    end
  endfunction : ok_pat
  function logic passed_line();
    passed_line = 1'b1;
    foreach (q[i]) if (q[i] !== lq[i]) passed_line = 1'b0;
  endfunction : passed_line
  task wait_live(input logic [7:0] e);
    int n;
    n = 0;
    do begin
      apb(1'b0, ilc_pkg::IDX_RX_LIVE, 8'h00);
      n++;
    end while (rd[7:0] !== e && n < 2000);
    chk("live status", {24'h0, e}, rd);
  endtask : wait_live
  initial begin
    repeat (60000) @(posedge pclk);
    errors++;
    finish_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, tx_bit_stb, tx_line_data, tx_fbit_slot} = 7'h00;
    {send_en, err_en, paddr, pwdata, pat, plen} = '0;
    void'($urandom(142));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ilc_pkg::IDX_PORT_CFG, 8'h00);
    chk("cfg reset", {24'h0, ilc_pkg::RST_CFG}, rd);
    apb(1'b0, ilc_pkg::IDX_RX_LATCHED, 8'h00);
    chk("latched reset", {24'h0, ilc_pkg::RST_BYTE}, rd);
    apb(1'b1, 10'h3FF, 8'hFF);
    chk("unmapped error", 32'h1, {31'h0, er});
    for (k = 0; k < 8; k++) begin
      p = lens[k];
      d1 = (k == 0) ? 8'h80 : 8'($urandom);
      d2 = (p == 16) ? 8'($urandom) : d1;
      apb(1'b1, ilc_pkg::IDX_TX_DEF1, d1);
      apb(1'b1, ilc_pkg::IDX_TX_DEF2, d2);
      apb(1'b1, ilc_pkg::IDX_TX_CTRL4, 8'(k));
      apb(1'b1, ilc_pkg::IDX_TX_CTRL3, 8'h01);
      tx_run(40, 1'b0);
      chk("tx code", 32'h1, {31'h0, ok_pat((p == 16) ? {d1, d2} : 16'(d1 >> (8 - p)), p)});
    end
    tx_run(4, 1'b1);
    chk("framing slot", 32'h1, {31'h0, passed_line()});
    apb(1'b1, ilc_pkg::IDX_PORT_CFG, 8'h03);
    tx_run(40, 1'b1);
    chk("no framing insert", 32'h1, {31'h0, ok_pat(16'(d1 >> 4), 4)});
    apb(1'b1, ilc_pkg::IDX_PORT_CFG, 8'h02);
    tx_run(8, 1'b0);
    chk("e1 mode tx", 32'h1, {31'h0, passed_line()});
    apb(1'b1, ilc_pkg::IDX_PORT_CFG, 8'h01);
    apb(1'b1, ilc_pkg::IDX_TX_CTRL3, 8'h00);
    tx_run(8, 1'b0);
    chk("tx stopped", 32'h1, {31'h0, passed_line()});
    apb(1'b1, ilc_pkg::IDX_RX_LEN_CTRL, 8'h2F);
    apb(1'b1, ilc_pkg::IDX_RX_UP_DEF1, 8'h80);
    apb(1'b1, ilc_pkg::IDX_RX_UP_DEF2, 8'h80);
    apb(1'b1, ilc_pkg::IDX_RX_DN_DEF1, 8'hE0);
    apb(1'b1, ilc_pkg::IDX_RX_SP_DEF1, 8'hA5);
    apb(1'b1, ilc_pkg::IDX_RX_SP_DEF2, 8'hC3);
    apb(1'b1, ilc_pkg::IDX_SP_LEN_CTRL, 8'h08);
    apb(1'b1, ilc_pkg::IDX_RX_MASK, 8'h07);
    err_en <= 1'b1;
    for (k = 0; k < 3; k++) begin
      pat <= pats[k];
      plen <= plens[k];
      send_en <= 1'b1;
      if (k == 0) begin
        repeat (10) begin
          repeat (100) @(posedge pclk);
          apb(1'b1, ilc_pkg::IDX_RX_UP_DEF1, 8'h80);
        end
        apb(1'b0, ilc_pkg::IDX_RX_LIVE, 8'h00);
        chk("restarted", 32'h0, rd);
      end
      wait_live(8'(1 << k));
      apb(1'b0, ilc_pkg::IDX_RX_LATCHED, 8'h00);
      chk("latched set", 32'(1 << k), rd);
      chk("irq", 32'h1, {31'h0, loop_code_irq_pend});
      apb(1'b1, ilc_pkg::IDX_RX_LATCHED, 8'hFF);
      apb(1'b0, ilc_pkg::IDX_RX_LATCHED, 8'h00);
      chk("latched clear", 32'h0, rd);
      send_en <= 1'b0;
      wait_live(8'h00);
      apb(1'b0, ilc_pkg::IDX_RX_LATCHED, 8'h00);
      chk("latched loss", 32'(8 << k), rd);
      apb(1'b1, ilc_pkg::IDX_RX_LATCHED, 8'hFF);
    end
    finish_test();
  end
endmodule : tb_t1_inband_loop_code_gen_detect

bind ilc_loop_code ilc_loop_code_assertions #(.PORT_NUM(PORT_NUM), .INTEG_BITS(INTEG_BITS)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_bit_stb(tx_bit_stb), .tx_line_data(tx_line_data), .tx_fbit_slot(tx_fbit_slot),
  .tx_out_data(tx_out_data), .rx_bit_stb(rx_bit_stb), .rx_line_data(rx_line_data),
  .loop_code_irq_pend(loop_code_irq_pend));
